// *** hdl/tmpa_pkg.sv ***
package tmpa_pkg;
  localparam int unsigned TMPA_NUM_MOD = 2;
  localparam int unsigned TMPA_CNT_W = 10;
  localparam int unsigned TMPA_ADDR_W = 7;

  // Register indices (address bits 4..2) inside one module's window, plus module stride
  localparam logic [2:0] TMPA_IDX_CTRL0 = 3'h0;
  localparam logic [2:0] TMPA_IDX_CTRL1 = 3'h1;
  localparam logic [2:0] TMPA_IDX_CNT_LO = 3'h2;
  localparam logic [2:0] TMPA_IDX_CNT_HI = 3'h3;
  localparam logic [2:0] TMPA_IDX_CMPA_LO = 3'h4;
  localparam logic [2:0] TMPA_IDX_CMPA_HI = 3'h5;
  localparam logic [6:0] TMPA_OFS_MOD1 = 7'h20;
  localparam logic [6:0] TMPA_OFS_PIN_EN = 7'h40;

  // Control 0 field positions
  localparam int unsigned TMPA_C0_PAUSE = 7;
  localparam int unsigned TMPA_C0_CLK_LSB = 4;
  localparam int unsigned TMPA_C0_ON = 3;
  localparam int unsigned TMPA_C0_PER_LSB = 0;
  // Control 1 field positions
  localparam int unsigned TMPA_C1_MODE_LSB = 6;
  localparam int unsigned TMPA_C1_IO_LSB = 4;
  localparam int unsigned TMPA_C1_OC = 3;
  localparam int unsigned TMPA_C1_POL = 2;
  localparam int unsigned TMPA_C1_DPX = 1;
  localparam int unsigned TMPA_C1_CCLR = 0;

  localparam logic [7:0] TMPA_CTRL0_RST = 8'h00;
  localparam logic [7:0] TMPA_CTRL1_RST = 8'h00;
  localparam logic [3:0] TMPA_PIN_EN_RST = 4'h5;

  // Counter clock select codes
  localparam logic [2:0] TMPA_CLK_SYS_DIV4 = 3'h0;
  localparam logic [2:0] TMPA_CLK_SYS = 3'h1;
  localparam logic [2:0] TMPA_CLK_HI_DIV16 = 3'h2;
  localparam logic [2:0] TMPA_CLK_HI_DIV64 = 3'h3;
  localparam logic [2:0] TMPA_CLK_LIRC = 3'h4;
  localparam logic [2:0] TMPA_CLK_NONE = 3'h5;
  localparam logic [2:0] TMPA_CLK_EXT_RISE = 3'h6;
  localparam logic [2:0] TMPA_CLK_EXT_FALL = 3'h7;

  // Divider terminal counts (high clock taken as the system clock)
  localparam logic [5:0] TMPA_DIV4_LAST = 6'h03;
  localparam logic [5:0] TMPA_DIV16_LAST = 6'h0f;
  localparam logic [5:0] TMPA_DIV64_LAST = 6'h3f;

  typedef enum logic [1:0] {
    TMPA_MODE_COMPARE,
    TMPA_MODE_UNDEF,
    TMPA_MODE_PWM,
    TMPA_MODE_TIMER
  } tmpa_mode_e;

  localparam logic [1:0] TMPA_IO_KEEP = 2'h0;
  localparam logic [1:0] TMPA_IO_LOW = 2'h1;
  localparam logic [1:0] TMPA_IO_HIGH = 2'h2;
  localparam logic [1:0] TMPA_IO_TOGGLE = 2'h3;
endpackage

// *** hdl/tmpa_top.sv ***
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - Two modules, 10-bit counter, 10-bit compare A
// - Select code 101 stops the counter clock
// - Select codes pick sys, high, RC, pin
// - Separate interrupt per comparator A and P
// - Match may clear counter and change output
// - Period compares counter bits 9..7; zero overflows
// - Input pin counts only when selected
// - External input counts rising or falling edge
// - Compare output mode: set, clear or toggle
// - PWM appears on the same output pins
// - One edge-aligned PWM, duty or period adjustable
// - Pin ownership follows on bit and compare or PWM mode
// - Unused pin returns to shared functions
// - Pin-enable bits 0..3 connect pins to timer
// - Low bytes reached through 8-bit holding buffer
// - Buffer moves only on high-byte access
// - Compare low write fills buffer only
// - Compare high write also loads buffered low
// - High read captures matching low byte
// - Low read returns holding buffer
module tmpa_top
  import tmpa_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [TMPA_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_lirc_clk,
  input wire logic [TMPA_NUM_MOD-1:0] i_external_count_input,
  output logic [TMPA_NUM_MOD-1:0] o_irq_cmp_a,
  output logic [TMPA_NUM_MOD-1:0] o_irq_cmp_p,
  output logic [TMPA_NUM_MOD-1:0] o_timer_output_pin_a,
  output logic [TMPA_NUM_MOD-1:0] o_timer_output_pin_a_oe_n,
  output logic [TMPA_NUM_MOD-1:0] o_timer_output_pin_b,
  output logic [TMPA_NUM_MOD-1:0] o_timer_output_pin_b_oe_n,
  output logic [TMPA_NUM_MOD-1:0] o_ext_input_used
);

  // Bus handshake: one wait cycle, then the access completes
  logic ack_ff;
  logic req;
  logic acc;
  logic wr_acc;
  logic rd_take;
  logic [7:0] wdat;
  logic pin_en_hit;

  assign req = i_avs_read | i_avs_write;
  assign acc = req & ack_ff;
  assign wr_acc = acc & i_avs_write & i_avs_byteenable[0];
  // Reads act at the taking edge, so the high byte and its low byte are one snapshot
  assign rd_take = i_avs_read & ~ack_ff;
  assign wdat = i_avs_writedata[7:0];
  assign pin_en_hit = (i_avs_address == TMPA_OFS_PIN_EN);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~(req & ~ack_ff);
    end
  end

  // Pin enable register
  logic [3:0] pin_en_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pin_en_ff <= TMPA_PIN_EN_RST;
    end else if (wr_acc && pin_en_hit) begin
      pin_en_ff <= wdat[3:0];
    end
  end

  // Shared clock-enable dividers
  logic [5:0] div_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      div_ff <= 6'h00;
    end else begin
      div_ff <= div_ff + 6'h01;
    end
  end

  // Low-speed RC clock arrives asynchronously
  logic [2:0] lirc_sync_ff;
  logic lirc_lvl_ff;
  logic lirc_tick_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      lirc_sync_ff <= 3'h0;
      lirc_lvl_ff <= 1'b0;
      lirc_tick_ff <= 1'b0;
    end else begin
      lirc_sync_ff <= {lirc_sync_ff[1:0], i_lirc_clk};
      lirc_tick_ff <= 1'b0;
      if (lirc_sync_ff[1] == lirc_sync_ff[2]) begin
        lirc_lvl_ff <= lirc_sync_ff[2];
        lirc_tick_ff <= lirc_sync_ff[2] & ~lirc_lvl_ff;
      end
    end
  end

  logic [7:0] rd_mod [TMPA_NUM_MOD];

  genvar g;
  generate
    for (g = 0; g < TMPA_NUM_MOD; g++) begin : g_mod
      logic hit;
      logic [2:0] idx;
      logic [7:0] ctrl0_ff;
      logic [7:0] ctrl1_ff;
      logic [9:0] cnt_ff;
      logic [9:0] cmpa_ff;
      logic [7:0] hold_ff;
      logic on_d_ff;
      logic [2:0] ext_sync_ff;
      logic ext_lvl_ff;
      logic ext_rise_ff;
      logic ext_fall_ff;
      logic tick;
      logic run;
      logic [2:0] clk_sel;
      logic [2:0] per;
      logic [1:0] mode;
      logic [1:0] io;
      logic on_rise;
      logic [9:0] nxt_cnt;
      logic match_a;
      logic match_p;
      logic out_ff;
      logic pwm_lvl;
      logic owns_pin;

      assign hit = (i_avs_address[6:5] == {1'b0, 1'(g)}) && (i_avs_address[1:0] == 2'h0);
      assign idx = i_avs_address[4:2];
      assign clk_sel = ctrl0_ff[TMPA_C0_CLK_LSB +: 3];
      assign per = ctrl0_ff[TMPA_C0_PER_LSB +: 3];
      assign mode = ctrl1_ff[TMPA_C1_MODE_LSB +: 2];
      assign io = ctrl1_ff[TMPA_C1_IO_LSB +: 2];
      assign on_rise = ctrl0_ff[TMPA_C0_ON] & ~on_d_ff;

      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          ctrl0_ff <= TMPA_CTRL0_RST;
          ctrl1_ff <= TMPA_CTRL1_RST;
        end else if (wr_acc && hit) begin
          if (idx == TMPA_IDX_CTRL0) begin
            ctrl0_ff <= wdat;
          end
          if (idx == TMPA_IDX_CTRL1) begin
            ctrl1_ff <= wdat;
          end
        end
      end

      // Private buffer per module keeps the two modules independent
      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          hold_ff <= 8'h00;
        end else if (wr_acc && hit && idx == TMPA_IDX_CMPA_LO) begin
          hold_ff <= wdat;
        end else if (rd_take && hit && idx == TMPA_IDX_CNT_HI) begin
          hold_ff <= cnt_ff[7:0];
        end else if (rd_take && hit && idx == TMPA_IDX_CMPA_HI) begin
          hold_ff <= cmpa_ff[7:0];
        end
      end

      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          cmpa_ff <= 10'h000;
        end else if (wr_acc && hit && idx == TMPA_IDX_CMPA_HI) begin
          cmpa_ff <= {wdat[1:0], hold_ff};
        end
      end

      // External count input, three-stage synchroniser
      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          ext_sync_ff <= 3'h0;
          ext_lvl_ff <= 1'b0;
          ext_rise_ff <= 1'b0;
          ext_fall_ff <= 1'b0;
        end else begin
          ext_sync_ff <= {ext_sync_ff[1:0], i_external_count_input[g]};
          ext_rise_ff <= 1'b0;
          ext_fall_ff <= 1'b0;
          if (ext_sync_ff[1] == ext_sync_ff[2]) begin
            ext_lvl_ff <= ext_sync_ff[2];
            ext_rise_ff <= ext_sync_ff[2] & ~ext_lvl_ff;
            ext_fall_ff <= ~ext_sync_ff[2] & ext_lvl_ff;
          end
        end
      end

      always_comb begin
        case (clk_sel)
          TMPA_CLK_SYS_DIV4: tick = (div_ff[1:0] == TMPA_DIV4_LAST[1:0]);
          TMPA_CLK_SYS: tick = 1'b1;
          TMPA_CLK_HI_DIV16: tick = (div_ff[3:0] == TMPA_DIV16_LAST[3:0]);
          TMPA_CLK_HI_DIV64: tick = (div_ff == TMPA_DIV64_LAST);
          TMPA_CLK_LIRC: tick = lirc_tick_ff;
          TMPA_CLK_EXT_RISE: tick = ext_rise_ff;
          TMPA_CLK_EXT_FALL: tick = ext_fall_ff;
          default: tick = 1'b0;
        endcase
      end

      assign run = tick & ctrl0_ff[TMPA_C0_ON] & ~ctrl0_ff[TMPA_C0_PAUSE];
      assign nxt_cnt = cnt_ff + 10'h001;
      // Zero period waits for the wrap at full count
      assign match_p = run && ((per == 3'h0) ? (nxt_cnt == 10'h000)
                                              : (nxt_cnt == {per, 7'h00}));
      assign match_a = run && (nxt_cnt == cmpa_ff);

      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          on_d_ff <= 1'b0;
        end else begin
          on_d_ff <= ctrl0_ff[TMPA_C0_ON];
        end
      end

      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          cnt_ff <= 10'h000;
        end else if (on_rise) begin
          cnt_ff <= 10'h000;
        end else if (run) begin
          if (ctrl1_ff[TMPA_C1_CCLR] ? match_a : match_p) begin
            cnt_ff <= 10'h000;
          end else begin
            cnt_ff <= nxt_cnt;
          end
        end
      end

      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          o_irq_cmp_a[g] <= 1'b0;
          o_irq_cmp_p[g] <= 1'b0;
        end else begin
          o_irq_cmp_a[g] <= match_a;
          o_irq_cmp_p[g] <= match_p;
        end
      end

      // Compare output state; restart loads the initial level
      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          out_ff <= 1'b0;
        end else if (on_rise) begin
          out_ff <= ctrl1_ff[TMPA_C1_OC];
        end else if (mode == TMPA_MODE_COMPARE && match_a) begin
          case (io)
            TMPA_IO_LOW: out_ff <= 1'b0;
            TMPA_IO_HIGH: out_ff <= 1'b1;
            TMPA_IO_TOGGLE: out_ff <= ~out_ff;
            default: out_ff <= out_ff;
          endcase
        end
      end

      // Edge-aligned PWM: duplex bit swaps which register sets duty
      always_comb begin
        case (io)
          TMPA_IO_KEEP: pwm_lvl = ~ctrl1_ff[TMPA_C1_OC];
          TMPA_IO_LOW: pwm_lvl = ctrl1_ff[TMPA_C1_OC];
          default: begin
            if (ctrl1_ff[TMPA_C1_DPX]) begin
              pwm_lvl = (cnt_ff[9:7] < per) ? ctrl1_ff[TMPA_C1_OC]
                                            : ~ctrl1_ff[TMPA_C1_OC];
            end else begin
              pwm_lvl = (cnt_ff < cmpa_ff) ? ctrl1_ff[TMPA_C1_OC]
                                           : ~ctrl1_ff[TMPA_C1_OC];
            end
          end
        endcase
      end

      assign owns_pin = ctrl0_ff[TMPA_C0_ON] &&
                        (mode == TMPA_MODE_COMPARE || mode == TMPA_MODE_PWM);

      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          o_timer_output_pin_a[g] <= 1'b0;
          o_timer_output_pin_b[g] <= 1'b0;
          o_timer_output_pin_a_oe_n[g] <= 1'b1;
          o_timer_output_pin_b_oe_n[g] <= 1'b1;
          o_ext_input_used[g] <= 1'b0;
        end else begin
          if (mode == TMPA_MODE_PWM) begin
            o_timer_output_pin_a[g] <= pwm_lvl ^ ctrl1_ff[TMPA_C1_POL];
            o_timer_output_pin_b[g] <= ~(pwm_lvl ^ ctrl1_ff[TMPA_C1_POL]);
          end else begin
            o_timer_output_pin_a[g] <= out_ff ^ ctrl1_ff[TMPA_C1_POL];
            o_timer_output_pin_b[g] <= ~(out_ff ^ ctrl1_ff[TMPA_C1_POL]);
          end
          o_timer_output_pin_a_oe_n[g] <= ~(owns_pin & pin_en_ff[2*g]);
          o_timer_output_pin_b_oe_n[g] <= ~(owns_pin & pin_en_ff[2*g+1]);
          o_ext_input_used[g] <= clk_sel[2] & clk_sel[1];
        end
      end

      always_comb begin
        case (idx)
          TMPA_IDX_CTRL0: rd_mod[g] = ctrl0_ff;
          TMPA_IDX_CTRL1: rd_mod[g] = ctrl1_ff;
          TMPA_IDX_CNT_LO: rd_mod[g] = hold_ff;
          TMPA_IDX_CNT_HI: rd_mod[g] = {6'h00, cnt_ff[9:8]};
          TMPA_IDX_CMPA_LO: rd_mod[g] = hold_ff;
          TMPA_IDX_CMPA_HI: rd_mod[g] = {6'h00, cmpa_ff[9:8]};
          default: rd_mod[g] = 8'h00;
        endcase
      end
    end
  endgenerate

  // Read data captured with the handshake so it stands in the answer cycle
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (rd_take) begin
      if (pin_en_hit) begin
        o_avs_readdata <= {28'h000_0000, pin_en_ff};
      end else if (g_mod[0].hit) begin
        o_avs_readdata <= {24'h00_0000, rd_mod[0]};
      end else if (g_mod[1].hit) begin
        o_avs_readdata <= {24'h00_0000, rd_mod[1]};
      end else begin
        o_avs_readdata <= 32'h0000_0000;
      end
    end
  end

endmodule

// *** tb/tmpa_pins_model.sv ***
`timescale 1ns/1ps
module tmpa_pins_model(
  input wire logic i_clk,
  input wire logic [1:0] i_ext_run,
  output logic [1:0] o_ext = 2'h0,
  output logic o_lirc = 1'b0
);
  logic [3:0] div_ff = 4'h0;
  // The RC clock runs free; count pins idle low between bursts
  always @(posedge i_clk) begin
    div_ff <= div_ff + 4'h1;
    if (div_ff[2:0] == 3'h7) o_lirc <= ~o_lirc;
    for (int m = 0; m < 2; m++) begin
      o_ext[m] <= i_ext_run[m] & (o_ext[m] ^ (div_ff[1:0] == 2'h3));
    end
  end
endmodule

// *** tb/tmpa_top_chk.sv ***
`timescale 1ns/1ps
module tmpa_top_chk
  import tmpa_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [TMPA_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [TMPA_NUM_MOD-1:0] o_irq_cmp_a,
  input wire logic [TMPA_NUM_MOD-1:0] o_irq_cmp_p,
  input wire logic [TMPA_NUM_MOD-1:0] o_timer_output_pin_a,
  input wire logic [TMPA_NUM_MOD-1:0] o_timer_output_pin_a_oe_n,
  input wire logic [TMPA_NUM_MOD-1:0] o_timer_output_pin_b,
  input wire logic [TMPA_NUM_MOD-1:0] o_timer_output_pin_b_oe_n
);
  logic [3:0] en_ff;
  logic [2:0] sel_ff;
  logic [3:0] idle_ff;
  logic wr_done;
  logic [3:0] oe_n;
  assign wr_done = !o_avs_waitrequest && i_avs_write && i_avs_byteenable[0];
  assign oe_n = {o_timer_output_pin_b_oe_n[1], o_timer_output_pin_a_oe_n[1],
                 o_timer_output_pin_b_oe_n[0], o_timer_output_pin_a_oe_n[0]};
  always_ff @(posedge i_clk) begin
    if (!i_rstn) en_ff <= TMPA_PIN_EN_RST;
    else if (wr_done && i_avs_address == TMPA_OFS_PIN_EN) en_ff <= i_avs_writedata[3:0];
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) sel_ff <= 3'h0;
    else if (wr_done && i_avs_address == 7'h00) sel_ff <= i_avs_writedata[6:4];
  end
  // Settle time covers the input synchronisers and the pending tick
  always_ff @(posedge i_clk) begin
    if (!i_rstn || sel_ff != TMPA_CLK_NONE) idle_ff <= 4'h0;
    else if (idle_ff != 4'hf) idle_ff <= idle_ff + 4'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_taken;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_answer;
    !o_avs_waitrequest;
  endsequence
  a_wait_one: assert property (s_taken |=> s_answer)
    else $error("request not answered after one wait cycle");
  a_answer_single: assert property (s_answer |=> o_avs_waitrequest)
    else $error("answer cycle longer than one");
  a_read_upper_zero: assert property (!o_avs_waitrequest && i_avs_read
    |-> o_avs_readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_pin_en_read: assert property (!o_avs_waitrequest && i_avs_read
    && i_avs_address == TMPA_OFS_PIN_EN |-> o_avs_readdata == {28'h0, en_ff})
    else $error("pin enable read back wrong");
  a_unmapped_read: assert property (!o_avs_waitrequest && i_avs_read
    && i_avs_address >= 7'h44 |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_pin_owner: assert property (((~oe_n) & ~(en_ff | $past(en_ff))) == 4'h0)
    else $error("pin driven while its enable is clear");
  a_pin_b_inv: assert property ($past(i_rstn) && $past(i_rstn, 2)
    |-> o_timer_output_pin_b == ~o_timer_output_pin_a)
    else $error("pin b not inverse of pin a");
  a_no_clock_irq: assert property (idle_ff == 4'hf
    |-> o_irq_cmp_a[0] == 1'b0 && o_irq_cmp_p[0] == 1'b0)
    else $error("interrupt with counter clock disconnected");
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import tmpa_pkg::*;
  logic i_clk = 0;
  logic i_rstn = 0;
  logic rd = 0;
  logic wr = 0;
  logic [6:0] adr = 0;
  logic [31:0] wdat = 0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [3:0] be = 4'hf;
  logic wreq;
  logic lirc;
  logic [1:0] ext, irqa, irqp, pa, paoe, pb, pboe, used;
  logic [1:0] run = 0;
  int miscompares = 0;
  int checks = 0;
  int seed = 32'h8426;
  always #5 i_clk = ~i_clk;
  tmpa_top i_tmpa_top(.i_clk(i_clk), .i_rstn(i_rstn), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_lirc_clk(lirc),
    .i_external_count_input(ext), .o_irq_cmp_a(irqa), .o_irq_cmp_p(irqp),
    .o_timer_output_pin_a(pa), .o_timer_output_pin_a_oe_n(paoe),
    .o_timer_output_pin_b(pb), .o_timer_output_pin_b_oe_n(pboe), .o_ext_input_used(used));
  tmpa_pins_model i_tmpa_pins_model(.i_clk(i_clk), .i_ext_run(run), .o_ext(ext),
    .o_lirc(lirc));
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic fail();
    miscompares++;
    $display("MISMATCH %0t wait ran out", $time);
    print_verdict();
  endtask
  task automatic bus(input logic w, input logic [6:0] a, input logic [7:0] d);
    int n;
    n = 0;
    adr <= a;
    rd <= !w;
    wr <= w;
    wdat <= {24'h0, d};
    @(posedge i_clk);
    while (wreq !== 1'b0) begin
      n++;
      if (n > 20) fail();
      @(posedge i_clk);
    end
    q = rdat;
    rd <= 0;
    wr <= 0;
    @(posedge i_clk);
  endtask
  function automatic logic [6:0] ad(input int m, input logic [2:0] i);
    return (m[0] ? TMPA_OFS_MOD1 : 7'h00) + {2'h0, i, 2'h0};
  endfunction
  function automatic int xgap(input logic [2:0] s, input int c);
    case (s)
      3'h0: return 4 * c;
      3'h1: return c;
      3'h2, 3'h4: return 16 * c;
      3'h3: return 64 * c;
      default: return 8 * c;
    endcase
  endfunction
  // Low byte first so the high write carries the buffered low byte along
  task automatic setc(input int m, input logic [9:0] v);
    bus(1, ad(m, TMPA_IDX_CMPA_LO), v[7:0]);
    bus(1, ad(m, TMPA_IDX_CMPA_HI), {6'h0, v[9:8]});
  endtask
  task automatic start(input int m, input logic [7:0] c1, input logic [7:0] c0);
    bus(1, ad(m, TMPA_IDX_CTRL0), 8'h00);
    bus(1, ad(m, TMPA_IDX_CTRL1), c1);
    bus(1, ad(m, TMPA_IDX_CTRL0), c0);
  endtask
  task automatic wait_irq(input int m, input bit p, output int n);
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
      if (n > 3000) fail();
    end while ((p ? irqp[m] : irqa[m]) !== 1'b1);
  endtask
  task automatic gap(input int m, input bit p, input int e);
    int n;
    wait_irq(m, p, n);
    wait_irq(m, p, n);
    cmp(n, e);
  endtask
  initial begin
    logic [9:0] v0, v1;
    logic [2:0] s;
    int n;
    repeat (6) @(posedge i_clk);
    i_rstn <= 1;
    @(posedge i_clk);
    bus(0, TMPA_OFS_PIN_EN, 8'h00);
    cmp(q, 32'h5);
    for (int i = 0; i < 6; i++) begin
      bus(0, ad(1, 3'(i)), 8'h00);
      cmp(q, 32'h0);
    end
    v0 = 10'($random(seed));
    bus(1, TMPA_OFS_PIN_EN, {4'h0, v0[3:0]});
    be <= 4'he;
    bus(1, TMPA_OFS_PIN_EN, 8'h0f);
    be <= 4'hf;
    bus(1, 7'h44, 8'hff);
    bus(0, 7'h44, 8'h00);
    cmp(q, 32'h0);
    bus(0, TMPA_OFS_PIN_EN, 8'h00);
    cmp(q, {28'h0, v0[3:0]});
    bus(1, TMPA_OFS_PIN_EN, 8'h05);
    repeat (4) begin
      v0 = 10'($random(seed));
      v1 = 10'($random(seed));
      bus(1, ad(0, TMPA_IDX_CMPA_LO), v0[7:0]);
      setc(1, v1);
      bus(1, ad(0, TMPA_IDX_CMPA_HI), {6'h0, v0[9:8]});
      bus(1, ad(0, TMPA_IDX_CMPA_LO), ~v0[7:0]);
      for (int m = 0; m < 2; m++) begin
        bus(0, ad(m, TMPA_IDX_CMPA_HI), 8'h00);
        cmp(q, m ? v1[9:8] : v0[9:8]);
        bus(0, ad(m, TMPA_IDX_CMPA_LO), 8'h00);
        cmp(q, m ? v1[7:0] : v0[7:0]);
      end
    end
    for (int i = 0; i < 8; i++) begin
      s = 3'(i);
      run <= {2{s[2] & s[1]}};
      if (s != TMPA_CLK_NONE) begin
        setc(i % 2, 10'h3);
        start(i % 2, 8'h31, {1'b0, s, 4'h8});
        @(posedge i_clk);
        cmp(used[i % 2], s[2] & s[1]);
        gap(i % 2, 0, xgap(s, 3));
      end
    end
    run <= 2'h0;
    setc(0, 10'h3ff);
    start(0, 8'h30, 8'h58);
    repeat (50) @(posedge i_clk);
    bus(0, ad(0, TMPA_IDX_CNT_HI), 8'h00);
    cmp(q, 32'h0);
    bus(0, ad(0, TMPA_IDX_CNT_LO), 8'h00);
    cmp(q, 32'h0);
    for (int io = 1; io < 4; io++) begin
      setc(0, 10'h3);
      start(0, {2'h0, 2'(io), io == 1, 3'h0}, 8'h38);
      repeat (20) @(posedge i_clk);
      cmp(pa[0], io == 1);
      wait_irq(0, 0, n);
      repeat (2) @(posedge i_clk);
      cmp(pa[0], io != 1);
      cmp(paoe[0], 1'b0);
    end
    bus(1, TMPA_OFS_PIN_EN, 8'h04);
    @(posedge i_clk);
    cmp(paoe[0], 1'b1);
    bus(1, TMPA_OFS_PIN_EN, 8'h05);
    v0 = 10'($random(seed));
    for (int k = 0; k < 2; k++) begin
      s = k ? v0[2:0] : 3'h0;
      start(1, 8'h00, {4'h1, 1'b1, s});
      gap(1, 1, s == 3'h0 ? 1024 : 128 * s);
    end
    v1 = 10'(v0[9:3]) + 10'h1;
    setc(0, v1);
    for (int k = 0; k < 2; k++) begin
      start(0, 8'hb8 | 8'(4 * k), 8'h19);
      repeat (300) @(posedge i_clk);
      n = 0;
      repeat (128) begin
        @(posedge i_clk);
        if (pa[0] === 1'b1) n++;
      end
      cmp(n, k ? 128 - v1 : v1);
    end
    print_verdict();
  end
endmodule
bind tmpa_top tmpa_top_chk i_tmpa_top_chk(.i_clk(i_clk), .i_rstn(i_rstn),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_irq_cmp_a(o_irq_cmp_a), .o_irq_cmp_p(o_irq_cmp_p),
  .o_timer_output_pin_a(o_timer_output_pin_a),
  .o_timer_output_pin_a_oe_n(o_timer_output_pin_a_oe_n),
  .o_timer_output_pin_b(o_timer_output_pin_b),
  .o_timer_output_pin_b_oe_n(o_timer_output_pin_b_oe_n));
